// ### design/cpu_seq_params.svh
`ifndef CPU_SEQ_PARAMS_SVH
`define CPU_SEQ_PARAMS_SVH

// Register map of the core registers.
`define SFR_STACK_TOP      8'h81
`define SFR_TABLE_LOW      8'h82
`define SFR_TABLE_HIGH     8'h83
`define SFR_STATUS_WORD    8'hD0
`define SFR_AUX_OPERAND    8'hF0
`define SFR_SPACE_BASE     8'h80

// Reset values.
`define RST_STACK_TOP      8'h07
`define RST_BYTE           8'h00
`define RST_WORD           16'h0000

// Status word field positions.
`define STAT_CARRY         7
`define STAT_HALF_CARRY    6
`define STAT_USER_ZERO     5
`define STAT_BANK_HIGH     4
`define STAT_BANK_LOW      3
`define STAT_SIGNED_RANGE  2
`define STAT_USER_ONE      1
`define STAT_ODD_ONES      0

// Timing.
`define MC_CLOCKS_SLOW     4'hC
`define MC_CLOCKS_FAST     4'h6
`define RESET_HOLD_MC      2'h2
`define BANK_SHIFT         3

// Opcodes that the sequencer itself must recognise.
`define OP_XMOVE_RD_TABLE  8'hE0
`define OP_XMOVE_RD_REG0   8'hE2
`define OP_XMOVE_RD_REG1   8'hE3
`define OP_XMOVE_WR_TABLE  8'hF0
`define OP_XMOVE_WR_REG0   8'hF2
`define OP_XMOVE_WR_REG1   8'hF3
`define OP_MULTIPLY        8'hA4
`define OP_DIVIDE          8'h84
`define OP_JUMP_INDEXED    8'h73

`endif

// ### design/cpu_seq_pkg.sv
package cpu_seq_pkg;
  typedef enum logic [2:0] {
    first_state  = 3'b000,
    second_state = 3'b001,
    third_state  = 3'b010,
    fourth_state = 3'b011,
    fifth_state  = 3'b100,
    sixth_state  = 3'b101
  } mc_state_t;

  typedef enum logic [2:0] {
    am_direct    = 3'b000,
    am_ind_reg   = 3'b001,
    am_ind_stack = 3'b010,
    am_ind_table = 3'b011,
    am_register  = 3'b100,
    am_idx_table = 3'b101,
    am_idx_pc    = 3'b110
  } addr_mode_t;

  typedef enum logic [1:0] {
    space_data = 2'b00,
    space_sfr  = 2'b01,
    space_code = 2'b10,
    space_ext  = 2'b11
  } addr_space_t;
endpackage

// ### design/cpu_seq_if.sv
interface seq_if;
  import cpu_seq_pkg::*;
  logic      six_mode;
  mc_state_t state;
  logic      phase;
  logic      mc_end;
  modport timer (input six_mode, output state, output phase, output mc_end);
  modport core  (output six_mode, input state, input phase, input mc_end);
endinterface

interface oper_if;
  import cpu_seq_pkg::*;
  addr_mode_t  mode;
  logic [7:0]  field;
  logic [7:0]  ri_data;
  logic [7:0]  stack_top;
  logic [15:0] table_base;
  logic [15:0] pc;
  logic [7:0]  acc;
  logic [1:0]  bank;
  logic [15:0] addr;
  addr_space_t space;
  logic [7:0]  ri_addr;
  modport gen  (input mode, field, ri_data, stack_top, table_base, pc, acc, bank,
                output addr, space, ri_addr);
  modport core (output mode, field, ri_data, stack_top, table_base, pc, acc, bank,
                input addr, space, ri_addr);
endinterface

// ### design/mc_timer.sv
`include "cpu_seq_params.svh"

module mc_timer
  import cpu_seq_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_sync_n,
  // Sequencer outputs.
  seq_if.timer     sq
);
  mc_state_t state_r;
  logic      phase_r;
  logic [3:0] clk_cnt_r;

  // In slow mode each phase is one clock; in fast mode a state is one clock.
  assign sq.state  = state_r;
  assign sq.phase  = phase_r;
  assign sq.mc_end = (state_r == sixth_state) && (sq.six_mode || phase_r);

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      phase_r <= 1'b0;
    end else if (sq.six_mode) begin
      phase_r <= 1'b0;
    end else begin
      phase_r <= ~phase_r;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_r <= first_state;
    end else if (sq.six_mode || phase_r) begin
      case (state_r)
        first_state:  state_r <= second_state;
        second_state: state_r <= third_state;
        third_state:  state_r <= fourth_state;
        fourth_state: state_r <= fifth_state;
        fifth_state:  state_r <= sixth_state;
        sixth_state:  state_r <= first_state;
        default:      state_r <= first_state;
      endcase
    end
  end

  // Clocks since the last machine-cycle end, read only by the check below.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      clk_cnt_r <= 4'h0;
    end else if (sq.mc_end) begin
      clk_cnt_r <= 4'h1;
    end else if (clk_cnt_r != 4'hF) begin
      clk_cnt_r <= clk_cnt_r + 4'h1;
    end
  end

  a_mc_length: assert property (@(posedge clk) disable iff (!rst_sync_n)
    sq.mc_end && $stable(sq.six_mode) && $past(sq.mc_end, 12) && !$past(sq.six_mode)
    |-> clk_cnt_r == `MC_CLOCKS_SLOW)
    else $error("slow machine cycle is not twelve clocks");
endmodule

// ### design/oper_addr_gen.sv
`include "cpu_seq_params.svh"

module oper_addr_gen
  import cpu_seq_pkg::*;
(
  // Operand request and result.
  oper_if.gen op
);
  function automatic logic [7:0] bank_reg(input logic [1:0] bank, input logic [2:0] idx);
    bank_reg = {3'h0, bank, idx};
  endfunction

  assign op.ri_addr = bank_reg(op.bank, {2'h0, op.field[0]});

  always_comb begin
    op.addr  = `RST_WORD;
    op.space = space_data;
    case (op.mode)
      am_direct: begin
        op.addr  = {8'h00, op.field};
        op.space = (op.field >= `SFR_SPACE_BASE) ? space_sfr : space_data;
      end
      am_ind_reg: begin
        op.addr  = {8'h00, op.ri_data};
        op.space = space_data;
      end
      am_ind_stack: begin
        op.addr  = {8'h00, op.stack_top};
        op.space = space_data;
      end
      am_ind_table: begin
        op.addr  = op.table_base;
        op.space = space_ext;
      end
      am_register: begin
        op.addr  = {8'h00, bank_reg(op.bank, op.field[2:0])};
        op.space = space_data;
      end
      am_idx_table: begin
        op.addr  = op.table_base + {8'h00, op.acc};
        op.space = space_code;
      end
      am_idx_pc: begin
        op.addr  = op.pc + {8'h00, op.acc};
        op.space = space_code;
      end
      default: begin
        op.addr  = `RST_WORD;
        op.space = space_data;
      end
    endcase
  end
endmodule

// ### design/cpu_cycle_sequencer_core_regs.sv
// How it works
// - Reset pin held high two machine cycles resets the core; the board must hold it.
// - A machine cycle lasts twelve or six clocks by the selected mode.
// - Each instruction takes exactly one, two or four machine cycles by opcode.
// - Every machine cycle is six states, each split in two phases in twelve-clock mode.
// - In twelve-clock mode every phase is one clock.
// - The opcode is latched into the instruction register in the first state.
// - A second program fetch happens in the fourth state.
// - A one-cycle instruction finishes at the end of the sixth state.
// - An external-move write changes no core register except the odd-ones flag and the program counter.
// - The odd-ones flag follows the parity of the accumulator.
// - Bank-select bits choose one of four banks for register instructions.
// - Status word at D0, reset zero, with carry down to odd-ones bits.
// - Stack pointer at 81, read/write, resets to 07.
// - Data pointer bytes at 82 and 83, read/write, reset to zero.
// - Direct addressing uses an 8-bit field, reaching internal RAM and SFRs only.
// - 8-bit indirect address comes from register zero or one, or the stack pointer.
// - 16-bit indirect address comes only from the data pointer.
// - A 3-bit opcode field picks one of eight bank registers.
// - Indexed reads are program memory only, base plus accumulator.
// - The indexed jump target is accumulator plus the base pointer.
// - Program memory is read-only and separate from data memory.
`include "cpu_seq_params.svh"

module cpu_cycle_sequencer_core_regs
  import cpu_seq_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        reset_pin,
  input  wire logic        six_clock_mode,
  // Program memory, read only.
  output logic [15:0]      code_addr,
  output logic             code_fetch,
  output logic             code_fetch2,
  input  wire logic [7:0]  code_data,
  // Core register access from the datapath.
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic [7:0]  sfr_wdata,
  output logic [7:0]       sfr_rdata,
  output logic             sfr_hit,
  // Datapath updates.
  input  wire logic [7:0]  acc,
  input  wire logic        alu_flags_we,
  input  wire logic        alu_carry,
  input  wire logic        alu_half,
  input  wire logic        alu_ovf,
  input  wire logic        stack_push,
  input  wire logic        stack_pop,
  input  wire logic        table_inc,
  input  wire logic        pc_load,
  input  wire logic [15:0] pc_load_val,
  // Operand addressing.
  input  wire addr_mode_t  oper_mode,
  input  wire logic [7:0]  oper_field,
  input  wire logic [7:0]  ri_data,
  output logic [15:0]      oper_addr,
  output addr_space_t      oper_space,
  output logic [7:0]       ri_addr,
  // Sequencer status.
  output logic             core_reset,
  output mc_state_t        mc_state,
  output logic             mc_phase,
  output logic [7:0]       instr_reg,
  output logic             instr_done,
  output logic             xmove_read_seen,
  output logic [7:0]       program_status_word,
  output logic [7:0]       stack_top_pointer,
  output logic [15:0]      table_base_pointer
);
  seq_if  sq ();
  oper_if op ();

  logic        rst_s1_r, rst_sync_n;
  logic        pin_s1_r, pin_s2_r;
  logic        mode_s1_r, mode_s2_r, mode_r;
  logic [1:0]  hold_cnt_r;
  logic        core_reset_r;
  logic        begin_r;
  logic [2:0]  mc_left_r;
  logic        done_r;
  logic [7:0]  ir_r;
  logic [15:0] pc_r;
  logic        fetch2_r;
  logic        fetch_r;
  logic        xmove_rd_r;
  logic [7:0]  status_r, stk_ptr_r, tbl_lo_r, tbl_hi_r, aux_r;
  logic [7:0]  rdata_r;
  logic        hit_r;
  logic [15:0] oper_addr_r;
  addr_space_t oper_space_r;
  logic [7:0]  ri_addr_r;
  mc_state_t   mc_state_r;
  logic        mc_phase_r;
  logic        opcode_slot, fetch2_slot, last_mc, wr_ok;

  function automatic logic [2:0] instr_mcs(input logic [7:0] o);
    logic [3:0] hi;
    logic [3:0] lo;
    hi = o[7:4];
    lo = o[3:0];
    if (o == `OP_MULTIPLY || o == `OP_DIVIDE) begin
      instr_mcs = 3'h4;
    end else if (lo == 4'h1 || (lo == 4'h0 && hi != 4'h0 && hi <= 4'h8) || (hi == 4'hB && lo >= 4'h4) ||
                 (hi == 4'hD && lo >= 4'h8) || (hi == 4'h8 && lo >= 4'h8) ||
                 (hi == 4'hA && lo >= 4'h8) ||
                 o inside {8'h02, 8'h12, 8'h22, 8'h32, 8'h43, 8'h53, 8'h63, 8'h72, 8'h73,
                           8'h82, 8'h83, 8'h85, 8'h86, 8'h87, 8'h90, 8'h92, 8'h93, 8'hA0,
                           8'hA3, 8'hA6, 8'hA7, 8'hB0, 8'hC0, 8'hD0, 8'hD5, 8'hE0, 8'hE2,
                           8'hE3, 8'hF0, 8'hF2, 8'hF3}) begin
      instr_mcs = 3'h2;
    end else begin
      instr_mcs = 3'h1;
    end
  endfunction

  function automatic logic is_xmove_wr(input logic [7:0] o);
    is_xmove_wr = (o == `OP_XMOVE_WR_TABLE) || (o == `OP_XMOVE_WR_REG0) || (o == `OP_XMOVE_WR_REG1);
  endfunction

  mc_timer u_timer (
    .clk        (clk),
    .rst_sync_n (rst_sync_n),
    .sq         (sq.timer)
  );

  oper_addr_gen u_addr (
    .op (op.gen)
  );

  // Reset release and pin synchronisers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_r   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1_r   <= 1'b1;
      rst_sync_n <= rst_s1_r;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_s1_r  <= 1'b0;
      pin_s2_r  <= 1'b0;
      mode_s1_r <= 1'b0;
      mode_s2_r <= 1'b0;
    end else begin
      pin_s1_r  <= reset_pin;
      pin_s2_r  <= pin_s1_r;
      mode_s1_r <= six_clock_mode;
      mode_s2_r <= mode_s1_r;
    end
  end

  // The pin must be seen high over two machine-cycle ends before the core resets.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      hold_cnt_r   <= 2'h0;
      core_reset_r <= 1'b1;
    end else begin
      if (!pin_s2_r) begin
        hold_cnt_r <= 2'h0;
      end else if (sq.mc_end && hold_cnt_r != `RESET_HOLD_MC) begin
        hold_cnt_r <= hold_cnt_r + 2'h1;
      end
      core_reset_r <= pin_s2_r && (hold_cnt_r == `RESET_HOLD_MC);
    end
  end

  // Cycle mode only changes between instructions or while held in reset.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mode_r <= 1'b0;
    end else if (core_reset_r || (done_r && sq.state == first_state && !sq.phase)) begin
      mode_r <= mode_s2_r;
    end
  end
  assign sq.six_mode = mode_r;

  assign opcode_slot = begin_r && !core_reset_r && sq.state == first_state && !sq.phase;
  assign fetch2_slot = !core_reset_r && sq.state == fourth_state && !sq.phase;
  assign last_mc     = !begin_r && (mc_left_r == 3'h0);
  assign wr_ok       = !(is_xmove_wr(ir_r) && !begin_r);

  // Instruction sequencing over machine cycles.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      begin_r   <= 1'b1;
      mc_left_r <= 3'h0;
      done_r    <= 1'b0;
      ir_r      <= `RST_BYTE;
    end else if (core_reset_r) begin
      begin_r   <= 1'b1;
      mc_left_r <= 3'h0;
      done_r    <= 1'b0;
      ir_r      <= `RST_BYTE;
    end else begin
      done_r <= sq.mc_end && last_mc;
      if (opcode_slot) begin
        ir_r      <= code_data;
        mc_left_r <= instr_mcs(code_data) - 3'h1;
        begin_r   <= 1'b0;
      end else if (sq.mc_end && !begin_r) begin
        if (last_mc) begin
          begin_r <= 1'b1;
        end else begin
          mc_left_r <= mc_left_r - 3'h1;
        end
      end
    end
  end

  // Program counter and fetch strobes; program memory is never written.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pc_r     <= `RST_WORD;
      fetch_r  <= 1'b0;
      fetch2_r <= 1'b0;
    end else begin
      fetch_r  <= opcode_slot;
      fetch2_r <= fetch2_slot;
      if (core_reset_r) begin
        pc_r <= `RST_WORD;
      end else if (pc_load) begin
        pc_r <= pc_load_val;
      end else if (sq.mc_end && last_mc && ir_r == `OP_JUMP_INDEXED) begin
        pc_r <= {tbl_hi_r, tbl_lo_r} + {8'h00, acc};
      end else if (opcode_slot) begin
        pc_r <= pc_r + 16'h0001;
      end
    end
  end

  // A read through the external move cannot be served; it is flagged for debug.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      xmove_rd_r <= 1'b0;
    end else if (core_reset_r) begin
      xmove_rd_r <= 1'b0;
    end else if (opcode_slot && (code_data == `OP_XMOVE_RD_TABLE || code_data == `OP_XMOVE_RD_REG0 ||
                                 code_data == `OP_XMOVE_RD_REG1)) begin
      xmove_rd_r <= 1'b1;
    end
  end

  // Status word: ALU flags win over a register write to the same bits.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      status_r <= `RST_BYTE;
    end else if (core_reset_r) begin
      status_r <= `RST_BYTE;
    end else begin
      if (wr_ok && sfr_wr && sfr_addr == `SFR_STATUS_WORD) begin
        status_r[7:1] <= sfr_wdata[7:1];
      end
      if (wr_ok && alu_flags_we) begin
        status_r[`STAT_CARRY]        <= alu_carry;
        status_r[`STAT_HALF_CARRY]   <= alu_half;
        status_r[`STAT_SIGNED_RANGE] <= alu_ovf;
      end
      status_r[`STAT_ODD_ONES] <= ^acc;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      stk_ptr_r <= `RST_STACK_TOP;
    end else if (core_reset_r) begin
      stk_ptr_r <= `RST_STACK_TOP;
    end else if (wr_ok && sfr_wr && sfr_addr == `SFR_STACK_TOP) begin
      stk_ptr_r <= sfr_wdata;
    end else if (wr_ok && stack_push) begin
      stk_ptr_r <= stk_ptr_r + 8'h01;
    end else if (wr_ok && stack_pop) begin
      stk_ptr_r <= stk_ptr_r - 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tbl_lo_r <= `RST_BYTE;
      tbl_hi_r <= `RST_BYTE;
    end else if (core_reset_r) begin
      tbl_lo_r <= `RST_BYTE;
      tbl_hi_r <= `RST_BYTE;
    end else if (wr_ok && sfr_wr && sfr_addr == `SFR_TABLE_LOW) begin
      tbl_lo_r <= sfr_wdata;
    end else if (wr_ok && sfr_wr && sfr_addr == `SFR_TABLE_HIGH) begin
      tbl_hi_r <= sfr_wdata;
    end else if (wr_ok && table_inc) begin
      {tbl_hi_r, tbl_lo_r} <= {tbl_hi_r, tbl_lo_r} + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      aux_r <= `RST_BYTE;
    end else if (core_reset_r) begin
      aux_r <= `RST_BYTE;
    end else if (wr_ok && sfr_wr && sfr_addr == `SFR_AUX_OPERAND) begin
      aux_r <= sfr_wdata;
    end
  end

  // Register read port: one clock of latency, unmapped addresses read zero.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rdata_r <= `RST_BYTE;
      hit_r   <= 1'b0;
    end else begin
      hit_r <= 1'b1;
      case (sfr_addr)
        `SFR_STACK_TOP:   rdata_r <= stk_ptr_r;
        `SFR_TABLE_LOW:   rdata_r <= tbl_lo_r;
        `SFR_TABLE_HIGH:  rdata_r <= tbl_hi_r;
        `SFR_STATUS_WORD: rdata_r <= status_r;
        `SFR_AUX_OPERAND: rdata_r <= aux_r;
        default: begin
          rdata_r <= `RST_BYTE;
          hit_r   <= 1'b0;
        end
      endcase
    end
  end

  assign op.mode       = oper_mode;
  assign op.field      = oper_field;
  assign op.ri_data    = ri_data;
  assign op.stack_top  = stk_ptr_r;
  assign op.table_base = {tbl_hi_r, tbl_lo_r};
  assign op.pc         = pc_r;
  assign op.acc        = acc;
  assign op.bank       = {status_r[`STAT_BANK_HIGH], status_r[`STAT_BANK_LOW]};

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      oper_addr_r  <= `RST_WORD;
      oper_space_r <= space_data;
      ri_addr_r    <= `RST_BYTE;
      mc_state_r   <= first_state;
      mc_phase_r   <= 1'b0;
    end else begin
      oper_addr_r  <= op.addr;
      oper_space_r <= op.space;
      ri_addr_r    <= op.ri_addr;
      mc_state_r   <= sq.state;
      mc_phase_r   <= sq.phase;
    end
  end

  assign code_addr           = pc_r;
  assign code_fetch          = fetch_r;
  assign code_fetch2         = fetch2_r;
  assign sfr_rdata           = rdata_r;
  assign sfr_hit             = hit_r;
  assign oper_addr           = oper_addr_r;
  assign oper_space          = oper_space_r;
  assign ri_addr             = ri_addr_r;
  assign core_reset          = core_reset_r;
  assign mc_state            = mc_state_r;
  assign mc_phase            = mc_phase_r;
  assign instr_reg           = ir_r;
  assign instr_done          = done_r;
  assign xmove_read_seen     = xmove_rd_r;
  assign program_status_word = status_r;
  assign stack_top_pointer   = stk_ptr_r;
  assign table_base_pointer  = {tbl_hi_r, tbl_lo_r};

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  sequence s_last_mc_end;
    sq.mc_end && last_mc && !core_reset_r;
  endsequence

  sequence s_fresh_opcode;
    opcode_slot;
  endsequence

  a_opcode_latch: assert property (s_fresh_opcode |=> ir_r == $past(code_data) && !begin_r)
    else $error("opcode not latched in first state");
  a_second_fetch: assert property (fetch2_r |-> $past(sq.state) == fourth_state)
    else $error("second fetch outside fourth state");
  a_done_timing: assert property (s_last_mc_end |=> done_r ##1 !done_r)
    else $error("instruction end not flagged after sixth state");
  a_instr_length: assert property (s_fresh_opcode ##1 (mc_left_r != 3'h0 && mc_left_r != 3'h1 &&
                                    mc_left_r != 3'h3) |-> 1'b0)
    else $error("instruction length not one, two or four cycles");
  a_odd_ones: assert property (!core_reset_r |=> status_r[`STAT_ODD_ONES] == ^$past(acc))
    else $error("odd-ones flag does not follow accumulator");
  a_xmove_quiet: assert property (!wr_ok && !core_reset_r && !pc_load |=>
                                   $stable(stk_ptr_r) && $stable(tbl_lo_r) && $stable(tbl_hi_r) && $stable(aux_r))
    else $error("external-move write changed state");
  a_reset_values: assert property (core_reset_r |=> stk_ptr_r == `RST_STACK_TOP &&
                                    {tbl_hi_r, tbl_lo_r} == `RST_WORD && status_r[7:1] == 7'h00)
    else $error("core reset values wrong");
  a_bank_base: assert property (oper_mode == am_register |=>
                                 oper_addr_r[7:0] == {3'h0, $past(op.bank), $past(oper_field[2:0])})
    else $error("register address not bank times eight");
  a_reset_hold: assert property (pin_s2_r && sq.mc_end && hold_cnt_r == 2'h1 |=> ##1 core_reset_r)
    else $error("held reset pin did not reset the core");
  a_index_jump: assert property ((s_last_mc_end and (ir_r == `OP_JUMP_INDEXED && !pc_load)) |=>
                                  pc_r == {$past(tbl_hi_r), $past(tbl_lo_r)} + {8'h00, $past(acc)})
    else $error("indexed jump target wrong");
endmodule

// ### tb/code_mem_model.sv
module code_mem_model (
  // Program memory port.
  input  wire logic [15:0] code_addr,
  output logic [7:0]       code_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // Every location holds a one-cycle no-op except one external-move write; no external-move read is fetched.
  assign code_data = (code_addr == 16'h00F0) ? 8'hF0 : 8'h00;
endmodule

// ### tb/cpu_cycle_sequencer_core_regs_tb.sv
module cpu_cycle_sequencer_core_regs_tb
  import cpu_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_n, reset_pin, six_clock_mode, sfr_wr, alu_flags_we, alu_carry, alu_half;
  logic        alu_ovf, stack_push, stack_pop, table_inc, pc_load, code_fetch, code_fetch2, sfr_hit;
  logic        core_reset, mc_phase, instr_done, xmove_read_seen, vld, vld_d, sel, sel_d;
  logic [7:0]  sfr_addr, sfr_wdata, acc, oper_field, ri_data, code_data, sfr_rdata, ri_addr;
  logic [7:0]  instr_reg, program_status_word, stack_top_pointer, w, v[4];
  logic [15:0] pc_load_val, code_addr, oper_addr, table_base_pointer, exp_q[$];
  addr_mode_t  oper_mode;
  addr_space_t oper_space;
  mc_state_t   mc_state;
  int          err_count, cmp_count;
  const logic [7:0] am[4] = '{8'h81, 8'h82, 8'h83, 8'hF0};

  cpu_cycle_sequencer_core_regs i_dut (.*);
  code_mem_model i_mem (.code_addr(code_addr), .code_data(code_data));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic close_out();
    if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    vld = 1'b0;
    @(negedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [8:0] e);
    sfr_addr = a;
    sfr_wr = 1'b0;
    sel = 1'b0;
    vld = 1'b1;
    exp_q.push_back({7'h00, e});
    @(negedge clk);
  endtask

  task automatic op(input addr_mode_t m, input logic [15:0] e);
    oper_mode = m;
    oper_field = $urandom;
    sfr_wr = 1'b0;
    sel = 1'b1;
    vld = 1'b1;
    exp_q.push_back(m == am_register ? {11'h000, w[4:3], oper_field[2:0]} :
                    m == am_direct ? {8'h00, oper_field} : e);
    @(negedge clk);
  endtask

  task automatic per(input int n);
    int c, f2, dn;
    c = 0;
    vld = 1'b0;
    sfr_wr = 1'b0;
    while (code_fetch !== 1'b1 && c < 50) begin
      @(negedge clk);
      c++;
    end
    c = 0;
    f2 = 0;
    dn = 0;
    do begin
      @(negedge clk);
      c++;
      if (code_fetch2 === 1'b1) f2 = c;
      if (instr_done === 1'b1) dn = c;
    end while (code_fetch !== 1'b1 && c < 50);
    chk(16'(c), 16'(n));
    chk(16'(f2), 16'(n / 2));
    chk(16'(dn), 16'(n - 1));
  endtask

  // The result of every request shows one clock later and is checked at the falling edge.
  always @(posedge clk) begin
    vld_d <= vld;
    sel_d <= sel;
  end
  always @(negedge clk) begin
    if (vld_d) chk(sel_d ? oper_addr : {7'h00, sfr_hit, sfr_rdata}, exp_q.pop_front());
  end

  initial begin
    #50000;
    err_count++;
    close_out();
  end

  initial begin
    {rst_n, reset_pin, six_clock_mode, sfr_wr, alu_flags_we, alu_carry, alu_half, alu_ovf} = '0;
    {stack_push, stack_pop, table_inc, pc_load, vld, sel, pc_load_val, ri_data} = '0;
    {sfr_addr, sfr_wdata, acc, oper_field} = '0;
    oper_mode = am_direct;
    err_count = 0;
    cmp_count = 0;
    w = $urandom(47600);
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (20) @(negedge clk);
    chk(core_reset, 1'b0);
    rd(8'h81, 9'h107);
    rd(8'h82, 9'h100);
    rd(8'h83, 9'h100);
    rd(8'hD0, 9'h100);
    rd(8'hF0, 9'h100);
    rd(8'h85, 9'h000);
    for (int i = 0; i < 4; i++) begin
      v[i] = $urandom;
      wr(am[i], v[i]);
      rd(am[i], {1'b1, v[i]});
    end
    acc = $urandom;
    w = $urandom;
    wr(8'hD0, w);
    rd(8'hD0, {1'b1, w[7:1], ^acc});
    acc = acc ^ 8'h01;
    vld = 1'b0;
    @(negedge clk);
    rd(8'hD0, {1'b1, w[7:1], ^acc});
    op(am_register, 16'h0000);
    op(am_direct, 16'h0000);
    op(am_ind_stack, {8'h00, v[0]});
    op(am_ind_table, {v[2], v[1]});
    op(am_idx_table, {v[2], v[1]} + 16'(acc));
    chk(oper_space, space_code);
    chk(ri_addr, {11'h000, w[4:3], 2'b00, oper_field[0]});
    chk(table_base_pointer, {v[2], v[1]});
    per(12);
    six_clock_mode = 1'b1;
    repeat (40) @(negedge clk);
    per(6);
    reset_pin = 1'b1;
    repeat (20) @(negedge clk);
    chk(core_reset, 1'b1);
    reset_pin = 1'b0;
    repeat (10) @(negedge clk);
    rd(8'h81, 9'h107);
    pc_load_val = 16'h00F0;
    pc_load = 1'b1;
    vld = 1'b0;
    @(negedge clk);
    pc_load = 1'b0;
    while (instr_reg !== 8'hF0) @(negedge clk);
    wr(8'hF0, 8'hA5);
    rd(8'hF0, 9'h100);
    chk(xmove_read_seen, 1'b0);
    vld = 1'b0;
    repeat (2) @(negedge clk);
    close_out();
  end
endmodule
